// ### design/ocd_decode.sv
// Purpose: Opcode decode, length, cycle count and flag update
// Assumes: Opcode presented by the fetch logic on the core clock
// Notes:   Unoccupied opcodes decode as a two-cycle no-operation
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - bit branch opcodes 2n/01+2n, 3 bytes, 5
// - bit set 10+2n, clear 11+2n, 2 bytes
// - accumulator/index RMW forms, one byte, 3 cycles
// - RMW memory forms direct, indexed, offset lengths
// - low nibble selects the RMW operation
// - memory-form test skips write-back, one cycle shorter
// - transfers and carry controls, two cycles
// - mask set/clear two cycles, clear zeroes mask
// - software trap ten, subroutine return six cycles
// - interrupt return nine cycles, reloads all flags
// - half carry changes only on add forms, MUL (cleared) and RTI (reloaded)
// - bit branch copies tested bit into carry
// - clear gives N=0 Z=1; NEG sets NZC, INC/DEC set NZ only
module ocd_decode (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rstn,
   // Opcode from fetch
   input  wire logic [7:0]        opcode,
   input  wire logic              opcode_valid,
   // Datapath results for the instruction completing
   input  wire logic              exec_done,
   input  wire ocd_pkg::ocd_alu_t alu,
   input  wire ocd_pkg::ocd_ccr_t stacked_ccr,
   // Decode and flags out
   output logic                   dec_valid,
   output ocd_pkg::ocd_dec_t      dec,
   output ocd_pkg::ocd_ccr_t      condition_code_register
);
   import ocd_pkg::*;

   typedef struct packed {
      ocd_dec_t dec;
      logic     valid;
      ocd_ccr_t condition_code_register;
   } ocd_state_t;

   ocd_state_t st_q;
   ocd_state_t st_d;

   // RMW operation from the low nibble; NONE for holes
   function automatic ocd_op_t rmw_op(input logic [3:0] lo);
      case (lo)
         LO_NEG:  rmw_op = OCD_NEG;
         LO_COM:  rmw_op = OCD_COM;
         LO_LSR:  rmw_op = OCD_LSR;
         LO_ROR:  rmw_op = OCD_ROR;
         LO_ASR:  rmw_op = OCD_ASR;
         LO_LSL:  rmw_op = OCD_LSL;
         LO_ROL:  rmw_op = OCD_ROL;
         LO_DEC:  rmw_op = OCD_DEC;
         LO_INC:  rmw_op = OCD_INC;
         LO_TST:  rmw_op = OCD_TST;
         LO_CLR:  rmw_op = OCD_CLR;
         default: rmw_op = OCD_NONE;
      endcase
   endfunction : rmw_op

   // Pure opcode decode
   function automatic ocd_dec_t decode(input logic [7:0] o);
      ocd_dec_t r;
      r.op      = OCD_NOP;
      r.mode    = OCD_M_INH;
      r.bit_sel = o[3:1];
      r.length  = LEN_1;
      r.cycles  = CYC_CTRL;
      r.illegal = 1'b0;
      case (o[7:4])
         HI_BIT_BRANCH: begin
            r.op     = o[0] ? OCD_BRANCH_IF_BIT_CLEAR_BIT : OCD_BRANCH_IF_BIT_SET_BIT;
            r.mode   = OCD_M_BTB;
            r.length = LEN_3;
            r.cycles = CYC_BTB;
         end
         HI_BIT_SETCLR: begin
            r.op     = o[0] ? OCD_CLRBIT : OCD_SETBIT;
            r.mode   = OCD_M_BSC;
            r.length = LEN_2;
            r.cycles = CYC_BSC;
         end
         HI_RMW_DIR, HI_RMW_ACC, HI_RMW_IDX, HI_RMW_IX1, HI_RMW_IX0: begin
            r.op = rmw_op(o[3:0]);
            case (o[7:4])
               HI_RMW_ACC: begin
                  r.mode = OCD_M_INH_A;
                  r.cycles = CYC_RMW_INH;
               end
               HI_RMW_IDX: begin
                  r.mode = OCD_M_INH_X;
                  r.cycles = CYC_RMW_INH;
               end
               HI_RMW_DIR: begin
                  r.mode = OCD_M_DIR;
                  r.length = LEN_2;
                  r.cycles = CYC_RMW_DIR;
               end
               HI_RMW_IX0: begin
                  r.mode = OCD_M_IX0;
                  r.cycles = CYC_RMW_IX0;
               end
               default: begin
                  r.mode = OCD_M_IX1;
                  r.length = LEN_2;
                  r.cycles = CYC_RMW_IX1;
               end
            endcase
            // Test only reads memory, so the write-back cycle drops out
            if (r.op == OCD_TST && o[7:4] != HI_RMW_ACC && o[7:4] != HI_RMW_IDX)
               r.cycles = r.cycles - 4'h1;
            if (o == OP_MUL) begin
               r.op = OCD_MUL;
               r.mode = OCD_M_INH;
               r.cycles = CYC_MUL;
            end
            if (r.op == OCD_NONE) begin
               r.op = OCD_NOP;
               r.mode = OCD_M_INH;
               r.length = LEN_1;
               r.cycles = CYC_CTRL;
               r.illegal = 1'b1;
            end
         end
         default: begin
            case (o)
               OP_TAX:  r.op = OCD_TAX;
               OP_TXA:  r.op = OCD_TXA;
               OP_SEC:  r.op = OCD_SEC;
               OP_CLC:  r.op = OCD_CLC;
               OP_SEI:  r.op = OCD_SEI;
               OP_CLI:  r.op = OCD_CLI;
               OP_RSP:  r.op = OCD_RSP;
               OP_NOP:  r.op = OCD_NOP;
               OP_STOP: r.op = OCD_STOP;
               OP_WAIT: r.op = OCD_WAIT;
               OP_SWI: begin
                  r.op = OCD_SWI;
                  r.cycles = CYC_SWI;
               end
               OP_RTS: begin
                  r.op = OCD_RTS;
                  r.cycles = CYC_RTS;
               end
               OP_RTI: begin
                  r.op = OCD_RTI;
                  r.cycles = CYC_RTI;
               end
               default: r.illegal = 1'b1;
            endcase
         end
      endcase
      return r;
   endfunction : decode

   // Next state: register the decode, then apply flags on completion
   always_comb begin
      ocd_ccr_t c;
      ocd_op_t  op;
      c = st_q.condition_code_register;
      op = st_q.dec.op;
      st_d = st_q;
      st_d.valid = opcode_valid;
      if (opcode_valid)
         st_d.dec = decode(opcode);
      // Half carry follows add forms with or without a decode; below, MUL clears it and RTI reloads it
      if (exec_done && alu.is_add)
         c.h = alu.half;
      if (exec_done && st_q.valid) begin
         case (op)
            OCD_BRANCH_IF_BIT_SET_BIT, OCD_BRANCH_IF_BIT_CLEAR_BIT: c.c = alu.tested_bit;
            OCD_CLR: begin
               c.n = 1'b0;
               c.z = 1'b1;
            end
            OCD_NEG, OCD_ROR, OCD_ASR, OCD_LSL, OCD_ROL: begin
               c.n = alu.result[7];
               c.z = (alu.result == 8'h00);
               c.c = alu.carry;
            end
            OCD_LSR: begin
               c.n = 1'b0;
               c.z = (alu.result == 8'h00);
               c.c = alu.carry;
            end
            OCD_COM: begin
               c.n = alu.result[7];
               c.z = (alu.result == 8'h00);
               c.c = 1'b1;
            end
            OCD_DEC, OCD_INC, OCD_TST: begin
               c.n = alu.result[7];
               c.z = (alu.result == 8'h00);
            end
            OCD_MUL: begin
               c.h = 1'b0;
               c.c = 1'b0;
            end
            OCD_SEC:  c.c = 1'b1;
            OCD_CLC:  c.c = 1'b0;
            OCD_SEI, OCD_SWI: c.i = 1'b1;
            OCD_CLI, OCD_STOP, OCD_WAIT: c.i = 1'b0;
            OCD_RTI:  c = stacked_ccr;
            default:  c = c;
         endcase
      end
      st_d.condition_code_register = c;
   end

   // State register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
         st_q.condition_code_register <= CCR_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign dec_valid = st_q.valid;
   assign dec = st_q.dec;
   assign condition_code_register = st_q.condition_code_register;

   // Bit branch decode lasts five cycles and three bytes
   a_btb_timing: assert property (@(posedge clock) disable iff (!rstn)
      opcode_valid && opcode[7:4] == 4'h0 |=> dec.cycles == 4'h5 && dec.length == 2'h3
      && dec.bit_sel == $past(opcode[3:1])) else $error("bit branch decode wrong");
   a_bsc_timing: assert property (@(posedge clock) disable iff (!rstn)
      opcode_valid && opcode[7:4] == 4'h1 |=> dec.cycles == 4'h5 && dec.length == 2'h2
      && (dec.op == OCD_CLRBIT) == $past(opcode[0])) else $error("bit set/clear decode wrong");
   a_rmw_inh: assert property (@(posedge clock) disable iff (!rstn)
      opcode_valid && (opcode == 8'h49 || opcode == 8'h59) |=> dec.op == OCD_ROL
      && dec.cycles == 4'h3 && dec.length == 2'h1) else $error("inherent rmw wrong");
   a_rmw_ix1: assert property (@(posedge clock) disable iff (!rstn)
      opcode_valid && opcode == 8'h66 |=> dec.op == OCD_ROR && dec.cycles == 4'h6
      && dec.length == 2'h2) else $error("offset rmw wrong");
   a_tst_short: assert property (@(posedge clock) disable iff (!rstn)
      opcode_valid && opcode == 8'h3D |=> dec.cycles == 4'h4) else $error("test cycles wrong");
   a_mul_cyc: assert property (@(posedge clock) disable iff (!rstn)
      opcode_valid && opcode == 8'h42 |=> dec.cycles == 4'hB && dec.op == OCD_MUL)
      else $error("multiply decode wrong");
   a_swi_cyc: assert property (@(posedge clock) disable iff (!rstn)
      opcode_valid && opcode == 8'h83 |=> dec.cycles == 4'hA) else $error("trap cycles wrong");
   a_rti_cyc: assert property (@(posedge clock) disable iff (!rstn)
      opcode_valid && opcode == 8'h80 |=> dec.cycles == 4'h9) else $error("rti cycles wrong");
   a_cli_mask: assert property (@(posedge clock) disable iff (!rstn)
      exec_done && dec_valid && dec.op == OCD_CLI |=> !condition_code_register.i) else $error("mask not cleared");
   a_clr_flags: assert property (@(posedge clock) disable iff (!rstn)
      exec_done && dec_valid && dec.op == OCD_CLR |=> !condition_code_register.n && condition_code_register.z) else $error("clear flags");
   a_half_hold: assert property (@(posedge clock) disable iff (!rstn)
      !exec_done || (!alu.is_add && dec.op != OCD_MUL && dec.op != OCD_RTI) |=> $stable(condition_code_register.h))
      else $error("half carry moved");
   a_hole_nop: assert property (@(posedge clock) disable iff (!rstn)
      opcode_valid && opcode == 8'h45 |=> dec.op == OCD_NOP && dec.illegal)
      else $error("hole not nop");

endmodule : ocd_decode
`default_nettype wire

// ### design/ocd_pkg.sv
// Purpose: Shared constants and types for the opcode decode part
// Assumes: 8-bit opcodes, one core clock
// Notes:   Cycle counts are whole instruction cycles as the core counts them
package ocd_pkg;

   // Opcode high nibbles for the mode groups
   localparam logic [3:0] HI_BIT_BRANCH = 4'h0;
   localparam logic [3:0] HI_BIT_SETCLR = 4'h1;
   localparam logic [3:0] HI_RMW_DIR    = 4'h3;
   localparam logic [3:0] HI_RMW_ACC    = 4'h4;
   localparam logic [3:0] HI_RMW_IDX    = 4'h5;
   localparam logic [3:0] HI_RMW_IX1    = 4'h6;
   localparam logic [3:0] HI_RMW_IX0    = 4'h7;

   // Read/modify/write low nibbles
   localparam logic [3:0] LO_NEG = 4'h0;
   localparam logic [3:0] LO_MUL = 4'h2;
   localparam logic [3:0] LO_COM = 4'h3;
   localparam logic [3:0] LO_LSR = 4'h4;
   localparam logic [3:0] LO_ROR = 4'h6;
   localparam logic [3:0] LO_ASR = 4'h7;
   localparam logic [3:0] LO_LSL = 4'h8;
   localparam logic [3:0] LO_ROL = 4'h9;
   localparam logic [3:0] LO_DEC = 4'hA;
   localparam logic [3:0] LO_INC = 4'hC;
   localparam logic [3:0] LO_TST = 4'hD;
   localparam logic [3:0] LO_CLR = 4'hF;

   // Control opcodes
   localparam logic [7:0] OP_RTI  = 8'h80;
   localparam logic [7:0] OP_RTS  = 8'h81;
   localparam logic [7:0] OP_SWI  = 8'h83;
   localparam logic [7:0] OP_STOP = 8'h8E;
   localparam logic [7:0] OP_WAIT = 8'h8F;
   localparam logic [7:0] OP_TAX  = 8'h97;
   localparam logic [7:0] OP_CLC  = 8'h98;
   localparam logic [7:0] OP_SEC  = 8'h99;
   localparam logic [7:0] OP_CLI  = 8'h9A;
   localparam logic [7:0] OP_SEI  = 8'h9B;
   localparam logic [7:0] OP_RSP  = 8'h9C;
   localparam logic [7:0] OP_NOP  = 8'h9D;
   localparam logic [7:0] OP_TXA  = 8'h9F;
   localparam logic [7:0] OP_MUL  = 8'h42;

   // Cycle counts
   localparam logic [3:0] CYC_BTB     = 4'h5;
   localparam logic [3:0] CYC_BSC     = 4'h5;
   localparam logic [3:0] CYC_RMW_INH = 4'h3;
   localparam logic [3:0] CYC_RMW_DIR = 4'h5;
   localparam logic [3:0] CYC_RMW_IX0 = 4'h5;
   localparam logic [3:0] CYC_RMW_IX1 = 4'h6;
   localparam logic [3:0] CYC_MUL     = 4'hB;
   localparam logic [3:0] CYC_CTRL    = 4'h2;
   localparam logic [3:0] CYC_SWI     = 4'hA;
   localparam logic [3:0] CYC_RTS     = 4'h6;
   localparam logic [3:0] CYC_RTI     = 4'h9;

   // Byte lengths
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;

   // Decoded operation
   typedef enum logic [4:0] {
      OCD_NONE, OCD_BRANCH_IF_BIT_SET_BIT, OCD_BRANCH_IF_BIT_CLEAR_BIT, OCD_SETBIT, OCD_CLRBIT,
      OCD_NEG, OCD_COM, OCD_LSR, OCD_ROR, OCD_ASR, OCD_LSL, OCD_ROL,
      OCD_DEC, OCD_INC, OCD_TST, OCD_CLR, OCD_MUL, OCD_TAX, OCD_TXA,
      OCD_SEC, OCD_CLC, OCD_SEI, OCD_CLI, OCD_SWI, OCD_RTS, OCD_RTI,
      OCD_RSP, OCD_NOP, OCD_STOP, OCD_WAIT
   } ocd_op_t;

   // Addressing mode
   typedef enum logic [2:0] {
      OCD_M_INH_A, OCD_M_INH_X, OCD_M_INH, OCD_M_DIR, OCD_M_IX0, OCD_M_IX1,
      OCD_M_BSC, OCD_M_BTB
   } ocd_mode_t;

   // Decode result carried to the sequencer
   typedef struct packed {
      ocd_op_t   op;
      ocd_mode_t mode;
      logic [2:0] bit_sel;
      logic [1:0] length;
      logic [3:0] cycles;
      logic       illegal;
   } ocd_dec_t;

   // Flags H I N Z C
   typedef struct packed {
      logic h;
      logic i;
      logic n;
      logic z;
      logic c;
   } ocd_ccr_t;

   // Flag update inputs from the datapath
   typedef struct packed {
      logic [7:0] result;
      logic       carry;
      logic       half;
      logic       tested_bit;
      logic       is_add;
   } ocd_alu_t;

   localparam ocd_ccr_t CCR_RESET = 5'h08;

endpackage : ocd_pkg

// ### bench/ocd_fetch_model.sv
// Purpose: Fetch-side model presenting opcode bytes to the decoder
// Assumes: One byte per request cycle, shown from the next edge
// Notes:   Released opcode lines invert every cycle, so they show the last byte again on alternate cycles
`timescale 1ns/1ps
`default_nettype none
module ocd_fetch_model (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rstn,
   // Requests from the bench
   input  wire logic       req,
   input  wire logic [7:0] req_byte,
   // Toward the decoder
   output var  logic [7:0] opcode,
   output var  logic       opcode_valid
);
   // Present a byte one edge after it is asked for
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         opcode_valid <= 1'b0;
         opcode       <= 8'hA5;
      end else begin
         opcode_valid <= req;
         opcode       <= req ? req_byte : ~opcode;
      end
   end
endmodule : ocd_fetch_model
`default_nettype wire

// ### bench/ocd_decode_tb.sv
// Purpose: Self-checking bench for the opcode decode part
// Assumes: Fetch model one edge ahead of the decoder
// Notes:   Expected decode and flags come from the bench's own tables
`timescale 1ns/1ps
`default_nettype none
module ocd_decode_tb;
   import ocd_pkg::*;
   typedef struct packed {
      logic [7:0] o;
      logic       fl;
      ocd_ccr_t   e;
   } ocd_note_t;
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic        req = 1'b0;
   logic [7:0]  req_byte = 8'h00;
   logic        exec_done = 1'b0;
   ocd_alu_t    alu = '0;
   ocd_ccr_t    stacked_ccr = '0;
   logic [7:0]  opcode;
   logic        opcode_valid;
   logic        dec_valid;
   ocd_dec_t    dec;
   ocd_ccr_t    condition_code_register;
   ocd_note_t   nq[$];
   ocd_ccr_t    eccr;
   logic [31:0] rv;
   int          n_fail = 0;
   int          cmp_count = 0;
   logic [31:0] rng = 32'h0000FE39; // Seed 65081

   always #5 clock = ~clock;

   ocd_fetch_model fm (.clock(clock), .rstn(rstn), .req(req), .req_byte(req_byte),
                       .opcode(opcode), .opcode_valid(opcode_valid));
   ocd_decode dut (.clock(clock), .rstn(rstn), .opcode(opcode), .opcode_valid(opcode_valid),
                   .exec_done(exec_done), .alu(alu), .stacked_ccr(stacked_ccr),
                   .dec_valid(dec_valid), .dec(dec), .condition_code_register(condition_code_register));

   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : rnd

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Flags after an instruction completes
   function automatic ocd_ccr_t nf(logic [7:0] o, ocd_alu_t a, ocd_ccr_t s, ocd_ccr_t c);
      logic [3:0] l;
      l = o[3:0];
      nf = c;
      if (a.is_add) nf.h = a.half;
      if (o[7:4] == 4'h0) nf.c = a.tested_bit;
      if (o == 8'h42) begin
         nf.h = 1'b0;
         nf.c = 1'b0;
      end else if (o[7:4] inside {[4'h3:4'h7]}) begin
         if (l inside {4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD}) begin
            nf.n = a.result[7];
            nf.z = (a.result == 8'h00);
         end
         if (l inside {4'h0, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9}) nf.c = a.carry;
         if (l == 4'h3) nf.c = 1'b1;
         if (l == 4'h4) nf.n = 1'b0;
         if (l == 4'hF) nf = '{h: nf.h, i: nf.i, n: 1'b0, z: 1'b1, c: nf.c};
      end
      case (o)
         8'h80:               nf = s;
         8'h83, 8'h9B:        nf.i = 1'b1;
         8'h8E, 8'h8F, 8'h9A: nf.i = 1'b0;
         8'h98:               nf.c = 1'b0;
         8'h99:               nf.c = 1'b1;
         default: ;
      endcase
   endfunction : nf

   // Expected decode; unoccupied places fall back to a flagged no-operation
   function automatic ocd_dec_t ed(logic [7:0] o);
      ocd_dec_t d;
      logic [3:0] h;
      h = o[7:4];
      d = '{op: OCD_NOP, mode: OCD_M_INH, bit_sel: o[3:1], length: 2'h1, cycles: 4'h2,
            illegal: 1'b1};
      if (h < 4'h2) begin
         d.illegal = 1'b0;
         d.op = (h == 4'h0) ? (o[0] ? OCD_BRANCH_IF_BIT_CLEAR_BIT : OCD_BRANCH_IF_BIT_SET_BIT)
                            : (o[0] ? OCD_CLRBIT : OCD_SETBIT);
         d.mode = (h == 4'h0) ? OCD_M_BTB : OCD_M_BSC;
         d.length = (h == 4'h0) ? 2'h3 : 2'h2;
         d.cycles = 4'h5;
      end else if (o == 8'h42) begin
         d = '{op: OCD_MUL, mode: OCD_M_INH, bit_sel: o[3:1], length: 2'h1, cycles: 4'hB,
               illegal: 1'b0};
      end else if (h inside {[4'h3:4'h7]}) begin
         d.illegal = 1'b0;
         case (o[3:0])
            4'h0: d.op = OCD_NEG;
            4'h3: d.op = OCD_COM;
            4'h4: d.op = OCD_LSR;
            4'h6: d.op = OCD_ROR;
            4'h7: d.op = OCD_ASR;
            4'h8: d.op = OCD_LSL;
            4'h9: d.op = OCD_ROL;
            4'hA: d.op = OCD_DEC;
            4'hC: d.op = OCD_INC;
            4'hD: d.op = OCD_TST;
            4'hF: d.op = OCD_CLR;
            default: d.illegal = 1'b1;
         endcase
         // Holes keep the one-byte two-cycle fallback, not the group's timing
         if (!d.illegal) begin
            d.mode = (h == 4'h3) ? OCD_M_DIR : (h == 4'h4) ? OCD_M_INH_A :
                     (h == 4'h5) ? OCD_M_INH_X : (h == 4'h6) ? OCD_M_IX1 : OCD_M_IX0;
            d.length = (h == 4'h3 || h == 4'h6) ? 2'h2 : 2'h1;
            d.cycles = (h == 4'h4 || h == 4'h5) ? 4'h3 : (h == 4'h6) ? 4'h6 : 4'h5;
            if (d.op == OCD_TST && !(h == 4'h4 || h == 4'h5)) d.cycles = d.cycles - 4'h1;
         end
      end else begin
         d.illegal = 1'b0;
         case (o)
            8'h80: begin
               d.op = OCD_RTI;
               d.cycles = 4'h9;
            end
            8'h81: begin
               d.op = OCD_RTS;
               d.cycles = 4'h6;
            end
            8'h83: begin
               d.op = OCD_SWI;
               d.cycles = 4'hA;
            end
            8'h8E: d.op = OCD_STOP;
            8'h8F: d.op = OCD_WAIT;
            8'h97: d.op = OCD_TAX;
            8'h98: d.op = OCD_CLC;
            8'h99: d.op = OCD_SEC;
            8'h9A: d.op = OCD_CLI;
            8'h9B: d.op = OCD_SEI;
            8'h9C: d.op = OCD_RSP;
            8'h9D: d.op = OCD_NOP;
            8'h9F: d.op = OCD_TXA;
            default: d.illegal = 1'b1;
         endcase
      end
      return d;
   endfunction : ed

   // Request one opcode; with fl set, complete it with random datapath values
   task automatic send(input logic [7:0] o, input logic fl);
      ocd_note_t n;
      logic [31:0] r;
      r = rnd();
      req = 1'b1;
      req_byte = o;
      if (fl) begin
         alu = ocd_alu_t'(r[11:0]);
         alu.is_add = 1'b0;
         stacked_ccr = ocd_ccr_t'(r[20:16]);
         eccr = nf(o, alu, stacked_ccr, eccr);
      end
      n = '{o: o, fl: fl, e: eccr};
      nq.push_back(n);
      @(posedge clock);
      #1;
      if (fl) begin
         req = 1'b0;
         @(posedge clock);
         #1;
         exec_done = 1'b1;
         @(posedge clock);
         #1;
         exec_done = 1'b0;
      end
   endtask : send

   // Bounded wait for every noted decode to be seen
   task automatic drain();
      // Step edge by edge so the next stimulus keeps the same offset
      for (int k = 0; k < 20 && nq.size() != 0; k++) begin
         @(posedge clock);
         #1;
      end
      if (nq.size() != 0) begin
         chk(32'h1, 32'h0);
         wrap_up();
      end
   endtask : drain

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   // Monitor: each decode takes the oldest note; completed ones also check flags
   always @(posedge clock) begin : mon
      ocd_note_t n;
      ocd_dec_t x;
      #2;
      if (dec_valid === 1'b1 && nq.size() == 0) chk(32'h1, 32'h0);
      else if (dec_valid === 1'b1) begin
         n = nq.pop_front();
         x = ed(n.o);
         chk(dec.op, x.op);
         chk(dec.length, x.length);
         chk(dec.cycles, x.cycles);
         chk(dec.illegal, x.illegal);
         if (!x.illegal) chk(dec.mode, x.mode);
         if (n.o[7:5] == 3'h0) chk(dec.bit_sel, x.bit_sel);
         if (n.fl) begin
            @(posedge clock);
            #2;
            chk(condition_code_register, n.e);
         end
      end
   end

   initial begin
      repeat (2) @(posedge clock);
      #1;
      rstn = 1'b1;
      eccr = 5'h08;
      chk(condition_code_register, eccr);
      chk(dec_valid, 1'b0);
      for (int i = 0; i < 256; i++) send(i[7:0], 1'b0);
      req = 1'b0;
      drain();
      $display("test decode_burst done");
      for (int i = 0; i < 256; i++) send(i[7:0], 1'b1);
      for (int i = 0; i < 64; i++) begin
         rv = rnd();
         send(rv[7:0], 1'b1);
      end
      drain();
      $display("test complete_flags done");
      // Half carry follows an add completing even with no decode pending
      rv = rnd();
      alu = ocd_alu_t'(rv[11:0]);
      alu.is_add = 1'b1;
      exec_done = 1'b1;
      eccr.h = alu.half;
      @(posedge clock);
      #1;
      exec_done = 1'b0;
      chk(condition_code_register, eccr);
      $display("test half_carry done");
      // Second reset in mid-run
      rstn = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk(condition_code_register, 5'h08);
      chk(dec_valid, 1'b0);
      rstn = 1'b1;
      eccr = 5'h08;
      send(8'h4F, 1'b1);
      drain();
      $display("test reset_again done");
      wrap_up();
   end
endmodule : ocd_decode_tb
`default_nettype wire
